// [strap_led_pkg.sv]
/*
  constants, field layouts and carrier types for the strap decode and
  led mapping block.
  assumes a single 40 mhz clock and an ahb-lite master for the registers.
*/
// Operation
// - no ext mii: leds are link_activity_led_n/act, duplex, 100m, 10m/link per mode.
// - with external mii, led 0 kept, leds 1 and 2 unused, led 3 is 100m.
// - strap high only when pulled high; don't-care straps are ignored.
// - boot rom strap picks decode: low uses second strap, high uses third.
// - wake output pulses when selecting strap low, holds level when high.
// - power event output pulses when selecting strap low, level when high.
// - led mode 0 when applicable led strap low, mode 1 when high.
// - polarity strap low makes wake active high, high makes it active low.
// - eeprom straps l,l,h use data bit 0 and rom select, else addr 2/5.
// - wake asserts on link change, magic packet or frame match; idles at the polarity strap level.
// - link+activity led held low while link up and flashes on traffic.
`default_nettype none

package strap_led_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  localparam int CTRL_EXT_MII_BIT   = 0;
  localparam int ST_WAKE_LEVEL_BIT  = 0;
  localparam int ST_PME_LEVEL_BIT   = 1;
  localparam int ST_LED_MODE_BIT    = 2;
  localparam int ST_WAKE_LOW_BIT    = 3;
  localparam int ST_EE_ALT_BIT      = 4;
  localparam int ST_BOOT_ROM_BIT    = 5;
  localparam int ST_WAKE_ACT_BIT    = 6;
  localparam int ST_PME_ACT_BIT     = 7;

  localparam logic       CTRL_EXT_MII_RST = 1'b0;
  localparam logic [3:0] LED_OFF_N        = 4'hf;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int WAKE_PULSE_NS = 1000;
  localparam int PULSE_CYC     = (WAKE_PULSE_NS * (CLK_HZ / 1_000_000)
                                  + 999) / 1000;
  localparam int BLINK_MS      = 50;
  localparam int BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic boot_rom;
    logic wake_level;
    logic pme_level;
    logic led_mode;
    logic wake_low;
    logic ee_alt;
  } options_t;

  typedef struct packed {
    options_t    opts;
    logic        ext_mii;
    logic        wake_act;
    logic [5:0]  wake_cnt;
    logic        pme_act;
    logic [5:0]  pme_cnt;
    logic [21:0] blink_cnt;
    logic        blink;
    logic [3:0]  leds_n;
    logic        wake_out;
    logic        pme_out;
    logic        ee_data;
    logic        rom_cs;
    logic        alt_cs;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
  } state_t;

endpackage : strap_led_pkg

`default_nettype wire

// [strap_decode_led_mapping.sv]
/*
  strap decode and led mapping: latches board straps during reset,
  decodes device options, drives four active-low leds, the wake and
  power event outputs and the eeprom pin selection; ahb-lite slave.
  assumes inputs synchronous to mclk and a zero-wait ahb-lite master.
*/
// Our own choices: the AHB-Lite register port and the address map.
`default_nettype none

module strap_decode_led_mapping
  import strap_led_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  // straps
  input  wire logic        boot_rom_present_strap,
  input  wire logic        wake_mode_strap,
  input  wire logic        wake_mode_alt_strap,
  input  wire logic        event_mode_strap,
  input  wire logic        event_mode_alt_strap,
  input  wire logic        led_mode_strap,
  input  wire logic        led_mode_alt_strap,
  input  wire logic        wake_polarity_strap,
  input  wire logic        eeprom_sel_strap_a,
  input  wire logic        eeprom_sel_strap_b,
  input  wire logic        eeprom_sel_strap_c,
  // link status and events
  input  wire logic        link_up,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        link_change_evt,
  input  wire logic        magic_packet_evt,
  input  wire logic        sample_frame_evt,
  input  wire logic        pme_evt,
  // eeprom pin sharing
  input  wire logic        mem_data_bit0_pin,
  input  wire logic        mem_addr_bit2_pin,
  input  wire logic        eeprom_cs_req,
  output var  logic        eeprom_data,
  output var  logic        boot_rom_select_pin,
  output var  logic        mem_addr_bit5_pin,
  // leds and wake
  output var  logic        link_activity_led_n,
  output var  logic        full_duplex_led_n,
  output var  logic        fast_link_led_n,
  output var  logic        slow_link_led_n,
  output var  logic        wake_output,
  output var  logic        pme_output
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // boot rom fitted selects the alternate strap, the other is don't-care
  function automatic logic pick(input logic boot, input logic primary,
                                input logic alt);
    pick = boot ? alt : primary;
  endfunction : pick

  localparam logic [21:0] BLINK_LAST = 22'(BLINK_CYCLES - 1);
  localparam logic [5:0]  PULSE_LOAD = 6'(PULSE_CYC);

  state_t   state_reg;
  state_t   state_next;
  options_t strap_opts;
  logic     activity;
  logic     link_activity_led_n_ind;
  logic     wake_trig;
  logic     addr_ok;
  logic     wr_ctrl;
  logic     wr_status;

  // -----------------------------------------------------------------
  // strap decode
  // -----------------------------------------------------------------
  always_comb begin
    strap_opts.boot_rom   = boot_rom_present_strap;
    strap_opts.wake_level = pick(boot_rom_present_strap, wake_mode_strap,
                                 wake_mode_alt_strap);
    strap_opts.pme_level  = pick(boot_rom_present_strap, event_mode_strap,
                                 event_mode_alt_strap);
    strap_opts.led_mode   = pick(boot_rom_present_strap, led_mode_strap,
                                 led_mode_alt_strap);
    strap_opts.wake_low   = wake_polarity_strap;
    strap_opts.ee_alt     = !(!eeprom_sel_strap_a && !eeprom_sel_strap_b
                              && eeprom_sel_strap_c);
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    activity     = tx_active || rx_active;
    link_activity_led_n_ind = link_up && !(activity && state_reg.blink);
    wake_trig    = link_change_evt || magic_packet_evt
                   || sample_frame_evt;
    addr_ok   = state_reg.dp_valid && state_reg.dp_write;
    wr_ctrl   = addr_ok && state_reg.dp_addr == CTRL_OFS;
    wr_status = addr_ok && state_reg.dp_addr == STATUS_OFS;

    // blink timebase for traffic flashing
    if (state_reg.blink_cnt == BLINK_LAST) begin
      state_next.blink_cnt = '0;
      state_next.blink     = !state_reg.blink;
    end else begin
      state_next.blink_cnt = state_reg.blink_cnt + 22'h1;
    end

    if (wr_ctrl) begin
      state_next.ext_mii = hwdata[CTRL_EXT_MII_BIT];
    end

    // wake: level mode is sticky until a one is written, set wins
    if (state_reg.opts.wake_level) begin
      if (wr_status && hwdata[ST_WAKE_ACT_BIT]) begin
        state_next.wake_act = 1'b0;
      end
      if (wake_trig) begin
        state_next.wake_act = 1'b1;
      end
    end else if (wake_trig) begin
      state_next.wake_act = 1'b1;
      state_next.wake_cnt = PULSE_LOAD;
    end else if (state_reg.wake_cnt > 6'h1) begin
      state_next.wake_cnt = state_reg.wake_cnt - 6'h1;
    end else begin
      state_next.wake_cnt = '0;
      state_next.wake_act = 1'b0;
    end

    if (state_reg.opts.pme_level) begin
      if (wr_status && hwdata[ST_PME_ACT_BIT]) begin
        state_next.pme_act = 1'b0;
      end
      if (pme_evt) begin
        state_next.pme_act = 1'b1;
      end
    end else if (pme_evt) begin
      state_next.pme_act = 1'b1;
      state_next.pme_cnt = PULSE_LOAD;
    end else if (state_reg.pme_cnt > 6'h1) begin
      state_next.pme_cnt = state_reg.pme_cnt - 6'h1;
    end else begin
      state_next.pme_cnt = '0;
      state_next.pme_act = 1'b0;
    end
    state_next.wake_out = state_next.wake_act ^ state_reg.opts.wake_low;
    state_next.pme_out  = state_next.pme_act;

    // led map
    if (state_reg.ext_mii) begin
      state_next.leds_n[0] = state_reg.opts.led_mode ?
                             !(activity && state_reg.blink) :
                             !link_activity_led_n_ind;
      state_next.leds_n[1] = 1'b1;
      state_next.leds_n[2] = 1'b1;
      state_next.leds_n[3] = !(link_up && speed_100);
    end else if (state_reg.opts.led_mode) begin
      state_next.leds_n[0] = !(activity && state_reg.blink);
      state_next.leds_n[1] = !full_duplex;
      state_next.leds_n[2] = !(link_up && speed_100);
      state_next.leds_n[3] = !link_up;
    end else begin
      state_next.leds_n[0] = !link_activity_led_n_ind;
      state_next.leds_n[1] = !full_duplex;
      state_next.leds_n[2] = !(link_up && speed_100);
      state_next.leds_n[3] = !(link_up && !speed_100);
    end

    // eeprom pin routing
    if (state_reg.opts.ee_alt) begin
      state_next.ee_data = mem_addr_bit2_pin;
      state_next.alt_cs  = eeprom_cs_req;
      state_next.rom_cs  = 1'b0;
    end else begin
      state_next.ee_data = mem_data_bit0_pin;
      state_next.rom_cs  = eeprom_cs_req;
      state_next.alt_cs  = 1'b0;
    end

    // ahb-lite: zero wait, read data prepared in the address phase
    state_next.dp_valid = hsel && htrans[1] && hready;
    state_next.dp_write = hwrite;
    state_next.dp_addr  = haddr[7:0];
    state_next.hrdata   = '0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[7:0] == CTRL_OFS) begin
        state_next.hrdata[CTRL_EXT_MII_BIT] = state_reg.ext_mii;
      end else if (haddr[7:0] == STATUS_OFS) begin
        state_next.hrdata[ST_WAKE_LEVEL_BIT] = state_reg.opts.wake_level;
        state_next.hrdata[ST_PME_LEVEL_BIT]  = state_reg.opts.pme_level;
        state_next.hrdata[ST_LED_MODE_BIT]   = state_reg.opts.led_mode;
        state_next.hrdata[ST_WAKE_LOW_BIT]   = state_reg.opts.wake_low;
        state_next.hrdata[ST_EE_ALT_BIT]     = state_reg.opts.ee_alt;
        state_next.hrdata[ST_BOOT_ROM_BIT]   = state_reg.opts.boot_rom;
        state_next.hrdata[ST_WAKE_ACT_BIT]   = state_reg.wake_act;
        state_next.hrdata[ST_PME_ACT_BIT]    = state_reg.pme_act;
      end
    end
    state_next.hreadyout = 1'b1;

    // straps follow the pins only while reset is held
    if (!reset_n) begin
      state_next           = '0;
      state_next.opts      = strap_opts;
      state_next.ext_mii   = CTRL_EXT_MII_RST;
      state_next.leds_n    = LED_OFF_N;
      state_next.wake_out  = strap_opts.wake_low;
      state_next.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    state_reg <= state_next;
  end

  assign hreadyout           = state_reg.hreadyout;
  assign hrdata              = state_reg.hrdata;
  assign hresp               = 1'b0;
  assign eeprom_data         = state_reg.ee_data;
  assign boot_rom_select_pin = state_reg.rom_cs;
  assign mem_addr_bit5_pin   = state_reg.alt_cs;
  assign link_activity_led_n = state_reg.leds_n[0];
  assign full_duplex_led_n   = state_reg.leds_n[1];
  assign fast_link_led_n     = state_reg.leds_n[2];
  assign slow_link_led_n     = state_reg.leds_n[3];
  assign wake_output         = state_reg.wake_out;
  assign pme_output          = state_reg.pme_out;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence reset_release_s;
    !reset_n ##1 reset_n;
  endsequence

  opts_hold_a: assert property (@(posedge mclk)
    disable iff (!reset_n) reset_n ##1 reset_n |-> $stable(state_reg.opts))
    else $error("options changed outside reset");
  wake_pick_a: assert property (@(posedge mclk)
    reset_release_s |-> state_reg.opts.wake_level ==
      ($past(boot_rom_present_strap, 2) ? $past(wake_mode_alt_strap, 2)
                                        : $past(wake_mode_strap, 2)))
    else $error("wake mode strap decoded wrongly");
  pme_pick_a: assert property (@(posedge mclk)
    reset_release_s |-> state_reg.opts.pme_level ==
      ($past(boot_rom_present_strap, 2) ? $past(event_mode_alt_strap, 2)
                                        : $past(event_mode_strap, 2)))
    else $error("event mode strap decoded wrongly");
  led_pick_a: assert property (@(posedge mclk)
    reset_release_s |-> state_reg.opts.led_mode ==
      ($past(boot_rom_present_strap, 2) ? $past(led_mode_alt_strap, 2)
                                        : $past(led_mode_strap, 2)))
    else $error("led mode strap decoded wrongly");
  wake_pol_a: assert property (@(posedge mclk)
    disable iff (!reset_n)
    wake_output == (state_reg.wake_act ^ state_reg.opts.wake_low))
    else $error("wake polarity wrong");
  ee_route_a: assert property (@(posedge mclk)
    disable iff (!reset_n)
    !state_reg.opts.ee_alt && eeprom_cs_req |=>
      boot_rom_select_pin && !mem_addr_bit5_pin)
    else $error("eeprom select not on rom select pin");
  // event in pulse mode, then two quiet cycles
  sequence wake_evt_quiet_s;
    !state_reg.opts.wake_level && link_change_evt ##1 !wake_trig [*2];
  endsequence

  wake_pulse_a: assert property (@(posedge mclk)
    disable iff (!reset_n) wake_evt_quiet_s |-> state_reg.wake_act)
    else $error("wake pulse too short");
  mii_leds_a: assert property (@(posedge mclk)
    disable iff (!reset_n)
    state_reg.ext_mii |=> full_duplex_led_n && fast_link_led_n)
    else $error("mii mode drives unused leds");
  slow_led_a: assert property (@(posedge mclk)
    disable iff (!reset_n)
    !state_reg.ext_mii && !state_reg.opts.led_mode && link_up && !speed_100
      |=> !slow_link_led_n && fast_link_led_n)
    else $error("10m link led wrong");
  link_led_a: assert property (@(posedge mclk)
    disable iff (!reset_n)
    !state_reg.ext_mii && !state_reg.opts.led_mode && link_up && !activity
      |=> !link_activity_led_n)
    else $error("link led not lit on idle link");

endmodule : strap_decode_led_mapping

`default_nettype wire

// [board_model.sv]
/*
  board model: strap resistors and status lamps beside the block.
  assumes the bench chooses which strap nets carry a pull-up.
*/
`default_nettype none

module board_model (
  // strap resistors
  input  wire logic [10:0] pull_up,
  output var  logic [10:0] strap_level,
  // lamps
  input  wire logic [3:0]  led_n,
  output var  logic [3:0]  lamp_lit
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // straps and lamps
  // ---------------------------------------------------------------
  // an unpulled strap sits on the weak pull-down, so it never reads high
  assign strap_level = pull_up;
  assign lamp_lit    = ~led_n;
endmodule : board_model

`default_nettype wire

// [strap_decode_led_mapping_tb_top.sv]
/*
  self-checking bench for the strap decode and led mapping block.
  assumes the package and design files are compiled first.
*/
`default_nettype none

module strap_decode_led_mapping_tb_top
  import strap_led_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BLINK = 8;

  logic        mclk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [10:0] pull, strap;
  logic [3:0]  evt, led_n, lamp;
  logic        link_up, speed_100, full_duplex, tx_active, rx_active;
  logic        data_pin0, addr_pin2, addr_pin5, cs_req;
  logic        ee_data, rom_cs, wake, pme;
  int          fails, cmp_count;

  board_model board_u (.pull_up(pull), .strap_level(strap),
                       .led_n(led_n), .lamp_lit(lamp));

  strap_decode_led_mapping #(.BLINK_CYCLES(BLINK)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .boot_rom_present_strap(strap[10]),
    .wake_mode_strap(strap[9]), .wake_mode_alt_strap(strap[8]),
    .event_mode_strap(strap[7]), .event_mode_alt_strap(strap[6]),
    .led_mode_strap(strap[5]), .led_mode_alt_strap(strap[4]),
    .wake_polarity_strap(strap[3]), .eeprom_sel_strap_a(strap[2]),
    .eeprom_sel_strap_b(strap[1]), .eeprom_sel_strap_c(strap[0]),
    .link_up(link_up), .speed_100(speed_100), .full_duplex(full_duplex),
    .tx_active(tx_active), .rx_active(rx_active),
    .link_change_evt(evt[0]), .magic_packet_evt(evt[1]),
    .sample_frame_evt(evt[2]), .pme_evt(evt[3]),
    .mem_data_bit0_pin(data_pin0), .mem_addr_bit2_pin(addr_pin2),
    .eeprom_cs_req(cs_req), .eeprom_data(ee_data),
    .boot_rom_select_pin(rom_cs), .mem_addr_bit5_pin(addr_pin5),
    .link_activity_led_n(led_n[3]), .full_duplex_led_n(led_n[2]),
    .fast_link_led_n(led_n[1]), .slow_link_led_n(led_n[0]),
    .wake_output(wake), .pme_output(pme));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // one single ahb-lite transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, exp);
    chk1(hresp, 1'b0);
  endtask : rd_chk

  // strap order: boot, wake, wake alt, event, event alt, led, led alt,
  // polarity, eeprom a, b, c
  function automatic logic [31:0] decode(input logic [10:0] p);
    logic b;
    b = p[10];
    return {26'h0, b, p[2:0] != 3'b001, p[3], b ? p[4] : p[5],
            b ? p[6] : p[7], b ? p[8] : p[9]};
  endfunction : decode

  // led order: link and traffic, duplex, fast link, slow link
  function automatic logic [3:0] led_exp(input logic mode, input logic mii,
                                         input logic spd, input logic fd);
    if (mii) return {mode, 1'b1, 1'b1, ~spd};
    return {mode, ~fd, ~spd, mode ? 1'b0 : spd};
  endfunction : led_exp

  task automatic fire(input int k, input logic lvl, input logic act);
    logic [31:0] r;
    @(posedge mclk) evt <= 4'(1 << k);
    @(posedge mclk) evt <= 4'h0;
    #1;
    chk1((k == 3) ? pme : wake, act);
    tick(PULSE_CYC - 1);
    chk1((k == 3) ? pme : wake, act);
    tick(1);
    chk1((k == 3) ? pme : wake, lvl ? act : ~act);
    if (lvl) begin
      bus(1'b1, STATUS_OFS,
          32'h1 << ((k == 3) ? ST_PME_ACT_BIT : ST_WAKE_ACT_BIT), r);
      tick(3);
      chk1((k == 3) ? pme : wake, ~act);
    end
  endtask : fire

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #500000;
    fails++;
    end_of_test();
  end

  initial begin
    logic [10:0] p;
    logic [31:0] st, r;
    logic [1:0]  seen;
    logic        alt, spd, fd;
    logic [3:0]  exp_led;
    logic [10:0] corner [4];
    corner = '{11'h000, 11'h7ff, 11'h001, 11'h4aa};
    void'($urandom(32'h4eff7825));
    {fails, cmp_count} = '0;
    {reset_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {pull, evt, link_up, speed_100, full_duplex} = '0;
    {tx_active, rx_active, data_pin0, addr_pin2, cs_req} = '0;
    for (int i = 0; i < 6; i++) begin
      p = (i < 4) ? corner[i] : 11'($urandom);
      @(posedge mclk);
      reset_n <= 1'b0;
      pull    <= p;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      st = decode(p);
      rd_chk(STATUS_OFS, st);
      rd_chk(CTRL_OFS, 32'h0);
      rd_chk(8'h10, 32'h0);
      chk1(wake, p[3]);
      // shared pins now carry memory traffic, options must not follow
      @(posedge mclk);
      pull   <= ~p;
      data_pin0 <= i[0];
      addr_pin2 <= ~i[0];
      cs_req <= 1'b1;
      tick(3);
      rd_chk(STATUS_OFS, st);
      alt = st[ST_EE_ALT_BIT];
      chk1(ee_data, alt ? ~i[0] : i[0]);
      chk1(rom_cs, ~alt);
      chk1(addr_pin5, alt);
      for (int m = 0; m < 2; m++) begin
        spd = 1'($urandom);
        fd  = 1'($urandom);
        bus(1'b1, CTRL_OFS, 32'(m), r);
        @(posedge mclk);
        link_up     <= 1'b1;
        speed_100   <= spd;
        full_duplex <= fd;
        tick(3);
        exp_led = led_exp(st[2], m[0], spd, fd);
        check(32'(led_n), 32'(exp_led));
        @(posedge mclk);
        tx_active <= m[0];
        rx_active <= ~m[0];
        seen = 2'b00;
        repeat (3 * BLINK) begin
          tick(1);
          seen = seen | (lamp[3] ? 2'b01 : 2'b10);
        end
        check({30'h0, seen}, 32'h3);
        @(posedge mclk);
        tx_active <= 1'b0;
        rx_active <= 1'b0;
        link_up   <= 1'b0;
      end
      fire(i % 3, st[0], ~p[3]);
      fire(3, st[1], 1'b1);
    end
    end_of_test();
  end
endmodule : strap_decode_led_mapping_tb_top

`default_nettype wire
